//--- logic/delay_counter.sv
// one-shot down counter that reports expiry
module delay_counter #(
    parameter int unsigned WIDTH = 24
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    // status
    output logic                  expired
);
    logic [WIDTH-1:0] count_q;

    // a counter narrower than two bits cannot hold a useful delay
    if (WIDTH < 2) begin : g_width_check
        $error("delay_counter width too small");
    end

    // a load of zero expires at once; load wins over counting
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= loadValue;
        end else if (count_q != '0) begin
            count_q <= count_q - WIDTH'(1);
        end
    end

    assign expired = (count_q == '0) && !load;

endmodule : delay_counter

//--- logic/wake_exit_delay_control.sv
// wake exit delay controller: picks and times the exit delay after a wake event

module wake_exit_delay_control #(
    parameter int unsigned PREP_CYCLES    = wake_exit_pkg::CPU_PREP_CYCLES,
    parameter int unsigned START_CYCLES   = wake_exit_pkg::STARTUP_CYCLES,
    parameter int unsigned LOCK_CYCLES    = wake_exit_pkg::LOCK_CYCLES,
    parameter int unsigned SETTLE_CYCLES  = wake_exit_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    // wake request and clock selection
    input  wire logic                     wakeEvent,
    input  wire logic                     primaryIdleMode,
    input  wire logic                     primaryRunning,
    input  wire wake_exit_pkg::clk_src_e  srcBefore,
    input  wire wake_exit_pkg::clk_src_e  srcAfter,
    // cpu side
    output logic                          cpuRun,
    output logic                          wakeBusy,
    // readiness flags of the oscillator control register
    output logic                          startupDoneFlag,
    output logic                          intOscStableFlag
);
    localparam int unsigned W = wake_exit_pkg::CNT_W;

    // a zero count would release before the counter is ever seen busy
    if (PREP_CYCLES < 1 || START_CYCLES < 1 || LOCK_CYCLES < 1 || SETTLE_CYCLES < 1)
    begin : g_min_check
        $error("delay counts must be at least one cycle");
    end
    if (PREP_CYCLES >= (1 << W) || START_CYCLES >= (1 << W)
        || LOCK_CYCLES >= (1 << W) || SETTLE_CYCLES >= (1 << W)) begin : g_range_check
        $error("delay count exceeds counter width");
    end

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT
    } wake_state_e;

    wake_state_e stateQ;
    logic        prepLoad, startLoad, lockLoad, settleLoad;
    logic        prepDone, startDone, lockDone, settleDone;
    logic        needStart, needLock, needSettle;
    logic        needStartQ, needLockQ;
    logic        cpuRun_q, wakeBusy_q, startupDone_q, intStable_q;
    logic        allDone;
    logic        lockStartedQ;
    wake_exit_pkg::clk_src_e srcAfterQ;

    // crystal family needs the start-up timer
    function automatic logic is_crystal(input wake_exit_pkg::clk_src_e s);
        return s == wake_exit_pkg::SRC_LOW_POWER_CRYSTAL
            || s == wake_exit_pkg::SRC_MEDIUM_CRYSTAL
            || s == wake_exit_pkg::SRC_HIGH_SPEED_CRYSTAL
            || s == wake_exit_pkg::SRC_HIGH_SPEED_MULT;
    endfunction : is_crystal

    always_comb begin
        // running primary skips timer in idle mode or with an unchanged source; non-crystal skips timer
        needStart = is_crystal(srcAfter)
                    && !(primaryIdleMode && primaryRunning)
                    && (srcBefore != srcAfter || !primaryRunning);
        needLock  = needStart && srcAfter == wake_exit_pkg::SRC_HIGH_SPEED_MULT;
        // fast internal covers the 8 MHz source and its taps
        needSettle = srcAfter == wake_exit_pkg::SRC_INT_FAST
                     && srcBefore != wake_exit_pkg::SRC_INT_FAST;
    end

    // prep, start-up and settle counters load only at the wake event in the run state; lock loads in the wait state
    assign prepLoad   = wakeEvent && stateQ == ST_RUN;
    assign startLoad  = prepLoad && needStart;
    assign settleLoad = prepLoad && needSettle;
    assign lockLoad   = stateQ == ST_WAIT && needLockQ && startDone && !lockStartedQ;

    delay_counter #(.WIDTH(W)) prepCnt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load      (prepLoad),
        .loadValue (W'(PREP_CYCLES)),
        .expired   (prepDone)
    );

    delay_counter #(.WIDTH(W)) startCnt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load      (startLoad),
        .loadValue (W'(START_CYCLES)),
        .expired   (startDone)
    );

    delay_counter #(.WIDTH(W)) lockCnt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load      (lockLoad),
        .loadValue (W'(LOCK_CYCLES)),
        .expired   (lockDone)
    );

    // settle time never stalls the cpu
    delay_counter #(.WIDTH(W)) settleCnt (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .load      (settleLoad),
        .loadValue (W'(SETTLE_CYCLES)),
        .expired   (settleDone)
    );

    // release only when prep and any needed start-up and lock delays have expired; settle is not waited for
    assign allDone = prepDone && (!needStartQ || startDone)
                     && (!needLockQ || (lockStartedQ && lockDone));

    // sequence state; new wakes while waiting are ignored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ       <= ST_RUN;
            needStartQ   <= 1'b0;
            needLockQ    <= 1'b0;
            lockStartedQ <= 1'b0;
        end else begin
            unique case (stateQ)
                ST_RUN: begin
                    if (wakeEvent) begin
                        stateQ       <= ST_WAIT;
                        needStartQ   <= needStart;
                        needLockQ    <= needLock;
                        lockStartedQ <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    if (lockLoad) begin
                        lockStartedQ <= 1'b1;
                    end
                    // resume the cycle after the delay ends
                    if (allDone) begin
                        stateQ <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // cpu run and busy, registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuRun_q   <= 1'b1;
            wakeBusy_q <= 1'b0;
        end else if (prepLoad) begin
            cpuRun_q   <= 1'b0;
            wakeBusy_q <= 1'b1;
        end else if (stateQ == ST_WAIT && allDone) begin
            cpuRun_q   <= 1'b1;
            wakeBusy_q <= 1'b0;
        end
    end

    // readiness flags; slow internal osc has none
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            startupDone_q <= 1'b0;
            intStable_q   <= 1'b0;
        end else begin
            if (startLoad) begin
                startupDone_q <= 1'b0;
            end else if (stateQ == ST_WAIT && needStartQ && startDone
                         && (!needLockQ || (lockStartedQ && lockDone))) begin
                startupDone_q <= 1'b1;
            end else if (prepLoad && is_crystal(srcAfter)) begin
                startupDone_q <= 1'b1;
            end
            if (settleLoad) begin
                intStable_q <= 1'b0;
            end else if (settleDone && srcAfterQ == wake_exit_pkg::SRC_INT_FAST) begin
                intStable_q <= 1'b1;
            end
        end
    end

    // remember the target source for flag ownership
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            srcAfterQ <= wake_exit_pkg::SRC_NONE;
        end else if (prepLoad) begin
            srcAfterQ <= srcAfter;
        end
    end

    assign cpuRun           = cpuRun_q;
    assign wakeBusy         = wakeBusy_q;
    assign startupDoneFlag  = startupDone_q;
    assign intOscStableFlag = intStable_q;

    // cpu held for at least the two cycles after the wake
    property p_prep_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        prepLoad |=> !cpuRun_q [*2];
    endproperty
    a_prep_hold: assert property (p_prep_hold) else $error("cpu ran before prep delay");

    // release follows all-done by one edge
    property p_release;
        @(posedge sys_clk) disable iff (!rst_n)
        (stateQ == ST_WAIT && allDone) |=> cpuRun_q;
    endproperty
    a_release: assert property (p_release) else $error("cpu not released after delay");

    // running primary in idle mode never loads the start-up timer
    property p_no_timer_idle;
        @(posedge sys_clk) disable iff (!rst_n)
        (primaryIdleMode && primaryRunning) |-> !startLoad;
    endproperty
    a_no_timer_idle: assert property (p_no_timer_idle) else $error("timer in idle");

    // non-crystal target never loads the start-up timer
    property p_no_timer_rc;
        @(posedge sys_clk) disable iff (!rst_n)
        !is_crystal(srcAfter) |-> !startLoad;
    endproperty
    a_no_timer_rc: assert property (p_no_timer_rc) else $error("timer for rc mode");

    // prep and start-up load together
    property p_parallel;
        @(posedge sys_clk) disable iff (!rst_n)
        startLoad |-> prepLoad;
    endproperty
    a_parallel: assert property (p_parallel) else $error("prep not parallel");

    // with prep and start-up both expired and no lock needed the release follows at once, no serial prep
    property p_no_serial;
        @(posedge sys_clk) disable iff (!rst_n)
        (stateQ == ST_WAIT && needStartQ && !needLockQ && prepDone && startDone) |=> cpuRun_q;
    endproperty
    a_no_serial: assert property (p_no_serial) else $error("prep added after start-up");

    // lock never starts before the start-up timer expired
    property p_lock_after;
        @(posedge sys_clk) disable iff (!rst_n)
        lockLoad |-> startDone && needLockQ;
    endproperty
    a_lock_after: assert property (p_lock_after) else $error("lock too early");

    // fast internal wake never stalls more than 301 cycles past the load
    property p_settle_run;
        @(posedge sys_clk) disable iff (!rst_n)
        settleLoad && !needStart |=> ##[0:300] cpuRun_q;
    endproperty
    a_settle_run: assert property (p_settle_run) else $error("stalled on settle");

    // release requires the start-up timer done
    property p_wait_start;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(cpuRun_q) && needStartQ |-> $past(startDone);
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("released before timer");

    c_wake: cover property (@(posedge sys_clk) disable iff (!rst_n) prepLoad);
    c_lock: cover property (@(posedge sys_clk) disable iff (!rst_n) lockLoad);
    c_settle: cover property (@(posedge sys_clk) disable iff (!rst_n) settleLoad);

endmodule : wake_exit_delay_control

//--- logic/wake_exit_pkg.sv
// constants and types shared by the wake exit delay controller
package wake_exit_pkg;

    // clock sources, before or after wake-up
    typedef enum logic [3:0] {
        SRC_NONE,                  // clock stopped (sleep)
        SRC_LOW_POWER_CRYSTAL,
        SRC_MEDIUM_CRYSTAL,
        SRC_HIGH_SPEED_CRYSTAL,
        SRC_HIGH_SPEED_MULT,       // crystal with multiplier
        SRC_EXT_RES_CAP,
        SRC_EXT_CLOCK,
        SRC_INT_OSC_IO,            // internal oscillator with io pins
        SRC_INT_SLOW,              // 31 kHz internal rc
        SRC_INT_FAST,              // 8 MHz source and its postscaler taps
        SRC_TIMER_SECONDARY
    } clk_src_e;

    // clock period in picoseconds at 250 MHz
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // cpu preparation delay, in ns (plain default; least time rounds up)
    localparam int unsigned CPU_PREP_NS     = 100;
    localparam int unsigned CPU_PREP_CYCLES =
        (CPU_PREP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // start-up timer interval, in oscillator periods counted by this clock
    localparam int unsigned STARTUP_CYCLES = 1024;

    // multiplier lock time, in us (least time rounds up)
    localparam int unsigned LOCK_US     = 2000;
    localparam int unsigned LOCK_CYCLES =
        (LOCK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // internal fast oscillator settle time, in us
    localparam int unsigned SETTLE_US     = 1;
    localparam int unsigned SETTLE_CYCLES =
        (SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // flag positions in the oscillator control status view
    localparam int unsigned STARTUP_DONE_BIT = 3;
    localparam int unsigned INT_STABLE_BIT   = 2;

    // counter width for all delay counters
    localparam int unsigned CNT_W = 24;

endpackage : wake_exit_pkg

//--- verification/wake_exit_delay_control_tb_top.sv
// self-checking testbench for the wake exit delay controller
module wake_exit_delay_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // short counts keep the run brief; prep is kept below start so the overlap shows
    localparam int unsigned PREP   = 4;
    localparam int unsigned START  = 10;
    localparam int unsigned LOCK   = 12;
    localparam int unsigned SETTLE = 20;

    logic                    sys_clk          = 1'b0;
    logic                    rst_n            = 1'b0;
    logic                    wakeEvent        = 1'b0;
    logic                    primaryIdleMode  = 1'b0;
    logic                    primaryRunning   = 1'b0;
    wake_exit_pkg::clk_src_e srcBefore        = wake_exit_pkg::SRC_NONE;
    wake_exit_pkg::clk_src_e srcAfter         = wake_exit_pkg::SRC_NONE;
    logic                    cpuRun;
    logic                    wakeBusy;
    logic                    startupDoneFlag;
    logic                    intOscStableFlag;
    int                      failures         = 0;
    int                      total_checks     = 0;
    int                      n;

    wake_exit_delay_control #(
        .PREP_CYCLES   (PREP),
        .START_CYCLES  (START),
        .LOCK_CYCLES   (LOCK),
        .SETTLE_CYCLES (SETTLE)
    ) dut_u (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .wakeEvent        (wakeEvent),
        .primaryIdleMode  (primaryIdleMode),
        .primaryRunning   (primaryRunning),
        .srcBefore        (srcBefore),
        .srcAfter         (srcAfter),
        .cpuRun           (cpuRun),
        .wakeBusy         (wakeBusy),
        .startupDoneFlag  (startupDoneFlag),
        .intOscStableFlag (intOscStableFlag)
    );

    // free-running 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    task automatic check_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_num(input string what, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : check_num

    // one wake; returns edges from the taking edge until cpuRun is seen high
    // poke fires a second request while busy, which must be ignored
    task automatic wake(input wake_exit_pkg::clk_src_e b, input wake_exit_pkg::clk_src_e a,
                        input logic idle, input logic run, input bit poke, output int cnt);
        @(negedge sys_clk);
        srcBefore       = b;
        srcAfter        = a;
        primaryIdleMode = idle;
        primaryRunning  = run;
        wakeEvent       = 1'b1;
        @(negedge sys_clk);
        wakeEvent = 1'b0;
        cnt       = 1;
        check_bit("cpuRun held", 1'b0, cpuRun);
        check_bit("wakeBusy", 1'b1, wakeBusy);
        while (cpuRun !== 1'b1 && cnt < 2000) begin
            if (poke) begin
                wakeEvent = (cnt == 2);
                srcAfter  = (cnt == 2) ? wake_exit_pkg::SRC_HIGH_SPEED_MULT : a;
            end
            @(negedge sys_clk);
            cnt++;
        end
        check_bit("wakeBusy released", 1'b0, wakeBusy);
    endtask : wake

    task automatic t_reset();
        check_bit("cpuRun reset", 1'b1, cpuRun);
        check_bit("wakeBusy reset", 1'b0, wakeBusy);
        check_bit("startupDone reset", 1'b0, startupDoneFlag);
        check_bit("intStable reset", 1'b0, intOscStableFlag);
    endtask : t_reset

    // non-crystal primaries only wait the prep delay
    task automatic t_no_timer();
        wake_exit_pkg::clk_src_e s [3];
        s = '{wake_exit_pkg::SRC_EXT_RES_CAP, wake_exit_pkg::SRC_EXT_CLOCK,
              wake_exit_pkg::SRC_INT_OSC_IO};
        foreach (s[i]) begin
            wake(wake_exit_pkg::SRC_NONE, s[i], 1'b0, 1'b0, 1'b0, n);
            check_num("prep only", PREP + 2, PREP + 2, n);
        end
    endtask : t_no_timer

    // crystal modes wait the start-up interval, prep overlapped
    task automatic t_crystal();
        wake_exit_pkg::clk_src_e s [3];
        s = '{wake_exit_pkg::SRC_LOW_POWER_CRYSTAL, wake_exit_pkg::SRC_MEDIUM_CRYSTAL,
              wake_exit_pkg::SRC_HIGH_SPEED_CRYSTAL};
        foreach (s[i]) begin
            wake(wake_exit_pkg::SRC_NONE, s[i], 1'b0, 1'b0, 1'b0, n);
            check_num("start-up wait", START + 2, START + 2, n);
            check_bit("startupDone", 1'b1, startupDoneFlag);
        end
    endtask : t_crystal

    // primary idle with the oscillator running skips the timer
    task automatic t_idle();
        wake(wake_exit_pkg::SRC_HIGH_SPEED_CRYSTAL, wake_exit_pkg::SRC_HIGH_SPEED_CRYSTAL,
             1'b1, 1'b1, 1'b0, n);
        check_num("idle exit", PREP + 2, PREP + 2, n);
        check_bit("startupDone idle", 1'b1, startupDoneFlag);
    endtask : t_idle

    // multiplier waits start-up then lock in sequence
    task automatic t_mult();
        wake(wake_exit_pkg::SRC_INT_SLOW, wake_exit_pkg::SRC_HIGH_SPEED_MULT,
             1'b0, 1'b0, 1'b0, n);
        check_num("start plus lock", START + LOCK + 2, START + LOCK + 3, n);
        check_bit("startupDone mult", 1'b1, startupDoneFlag);
    endtask : t_mult

    // fast internal osc runs the cpu during settle, flag comes later
    task automatic t_fast();
        wake(wake_exit_pkg::SRC_NONE, wake_exit_pkg::SRC_INT_FAST, 1'b0, 1'b0, 1'b0, n);
        check_num("fast internal", PREP + 2, PREP + 2, n);
        check_bit("intStable early", 1'b0, intOscStableFlag);
        repeat (SETTLE + 2) @(negedge sys_clk);
        check_bit("intStable late", 1'b1, intOscStableFlag);
        check_bit("cpuRun settle", 1'b1, cpuRun);
    endtask : t_fast

    // slow internal rc takes the prep delay only
    task automatic t_slow();
        wake(wake_exit_pkg::SRC_INT_FAST, wake_exit_pkg::SRC_INT_SLOW, 1'b0, 1'b0, 1'b0, n);
        check_num("slow internal", PREP + 2, PREP + 2, n);
    endtask : t_slow

    // a request while busy neither re-picks the delay nor queues
    task automatic t_refuse();
        wake(wake_exit_pkg::SRC_NONE, wake_exit_pkg::SRC_EXT_CLOCK, 1'b0, 1'b0, 1'b1, n);
        check_num("busy request ignored", PREP + 2, PREP + 2, n);
        repeat (3) @(negedge sys_clk);
        check_bit("no queued wake", 1'b1, cpuRun);
    endtask : t_refuse

    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // main sequence: reset held for eight cycles, then each scenario
    initial begin
        repeat (4) @(negedge sys_clk);
        t_reset();
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        t_no_timer();
        t_crystal();
        t_idle();
        t_mult();
        t_fast();
        t_slow();
        t_refuse();
        complete_run();
    end

    // watchdog at 5000 cycles, well beyond the 150 or so cycles the scenarios need
    initial begin
        #(4 * 5000);
        failures++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end
endmodule : wake_exit_delay_control_tb_top
